/* logic/atd_pkg.sv */
// Purpose: Shared constants for the accumulator transfer decode block
// Assumes: 10-bit instruction words, 4-bit accumulator and data nibbles
// Notes:   Opcodes are full 10-bit patterns; the RAM store keeps a 4-bit immediate field

package atd_pkg;

	// Data and instruction widths
	localparam int unsigned NIBBLE_W = 4;
	localparam int unsigned INSTR_W  = 10;

	// Single-word transfer opcodes
	localparam logic [9:0] OPC_LOAD_KEY_CTRL_2     = 10'h215;
	localparam logic [9:0] OPC_LOAD_DISPLAY_CTRL_1 = 10'h20A;
	localparam logic [9:0] OPC_LOAD_DISPLAY_CTRL_2 = 10'h20B;
	localparam logic [9:0] OPC_LOAD_DISPLAY_CTRL_3 = 10'h20C;
	localparam logic [9:0] OPC_LOAD_DISPLAY_TIMER  = 10'h20D;

	// RAM store: upper six bits fixed, low four bits are the immediate field
	localparam logic [5:0] OPC_STORE_TO_RAM_HI = 6'h2B;
	localparam int unsigned IMM_POS            = 0;
	localparam int unsigned IMM_W              = 4;

	// Every instruction of this group is one word and one cycle
	localparam int unsigned INSTR_WORDS  = 1;
	localparam int unsigned INSTR_CYCLES = 1;

	// Values after reset
	localparam logic [3:0] NIBBLE_RESET = 4'h0;

	// Operation groups reported for the decoded word
	typedef enum logic [2:0] {
		ATD_GRP_NONE,
		ATD_GRP_IO,
		ATD_GRP_DISPLAY,
		ATD_GRP_TIMER,
		ATD_GRP_RAM
	} atd_group_t;

endpackage

/* logic/atd_nibble_reg.sv */
// Purpose: One 4-bit control register loaded from the accumulator
// Assumes: Synchronous active-high reset on mclk
// Notes:   Used once per control register of the transfer group

`timescale 1ns/1ps

module atd_nibble_reg #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] data,
	output logic      [WIDTH-1:0] value_q
);

	// Hold the value until a load arrives
	always_ff @(posedge mclk) begin
		if (reset) begin
			value_q <= WIDTH'(atd_pkg::NIBBLE_RESET);
		end else if (load) begin
			value_q <= data;
		end
	end

endmodule // atd_nibble_reg

/* logic/atd_decode.sv */
// Purpose: Decode and execute accumulator-to-register transfer instructions
// Assumes: One instruction word presented per cycle with instr_valid; tick from mclk domain
// Notes:   Each transfer is one word and completes in the cycle it is presented

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////////////////////////
module atd_decode #(
	parameter int unsigned PTR_W = 6
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             instr_valid,
	input  wire logic [9:0]       instr_word,
	input  wire logic [3:0]       accumulator,
	input  wire logic [PTR_W-1:0] ram_pointer,
	input  wire logic             timer_tick,
	output logic      [3:0]       key_wakeup_ctrl_2,
	output logic      [3:0]       display_ctrl_1,
	output logic      [3:0]       display_ctrl_2,
	output logic      [3:0]       display_ctrl_3,
	output logic      [3:0]       display_clock_timer,
	output logic      [3:0]       display_timer_reload,
	output logic                  timer_underflow_q,
	output logic                  ram_wr_en_q,
	output logic      [PTR_W-1:0] ram_wr_addr_q,
	output logic      [3:0]       ram_wr_data_q,
	output logic      [3:0]       ram_imm_q,
	output logic      [2:0]       op_group_q,
	output logic                  instr_done_q,
	output logic                  carry_write_q,
	output logic                  skip_next_q
);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Decode

	logic op_load_key_ctrl_2;
	logic op_load_display_ctrl_1;
	logic op_load_display_ctrl_2;
	logic op_load_display_ctrl_3;
	logic op_load_display_clock_timer;
	logic op_store_to_ram;
	logic any_op;
	atd_pkg::atd_group_t group_d;

	// Exact 10-bit matches gated by a valid word
	assign op_load_key_ctrl_2 = instr_valid
		&& (instr_word == atd_pkg::OPC_LOAD_KEY_CTRL_2);
	assign op_load_display_ctrl_1 = instr_valid
		&& (instr_word == atd_pkg::OPC_LOAD_DISPLAY_CTRL_1);
	assign op_load_display_ctrl_2 = instr_valid
		&& (instr_word == atd_pkg::OPC_LOAD_DISPLAY_CTRL_2);
	assign op_load_display_ctrl_3 = instr_valid
		&& (instr_word == atd_pkg::OPC_LOAD_DISPLAY_CTRL_3);
	assign op_load_display_clock_timer = instr_valid
		&& (instr_word == atd_pkg::OPC_LOAD_DISPLAY_TIMER);
	// Upper six bits only; the immediate field is a don't-care for the match
	assign op_store_to_ram = instr_valid
		&& (instr_word[9:4] == atd_pkg::OPC_STORE_TO_RAM_HI);

	assign any_op = op_load_key_ctrl_2 || op_load_display_ctrl_1 || op_load_display_ctrl_2
		|| op_load_display_ctrl_3 || op_load_display_clock_timer || op_store_to_ram;

	// Operation group of the decoded word
	always_comb begin
		group_d = atd_pkg::ATD_GRP_NONE;
		if (op_load_key_ctrl_2) begin
			group_d = atd_pkg::ATD_GRP_IO;
		end else if (op_load_display_ctrl_1 || op_load_display_ctrl_2
				|| op_load_display_ctrl_3) begin
			group_d = atd_pkg::ATD_GRP_DISPLAY;
		end else if (op_load_display_clock_timer) begin
			group_d = atd_pkg::ATD_GRP_TIMER;
		end else if (op_store_to_ram) begin
			group_d = atd_pkg::ATD_GRP_RAM;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Control registers

	// Key-on wakeup control 2
	atd_nibble_reg #(
		.WIDTH (4)
	) u_key_ctrl_2 (
		.mclk    (mclk),
		.reset   (reset),
		.load    (op_load_key_ctrl_2),
		.data    (accumulator),
		.value_q (key_wakeup_ctrl_2)
	);

	// Display control 1
	atd_nibble_reg #(
		.WIDTH (4)
	) u_display_ctrl_1 (
		.mclk    (mclk),
		.reset   (reset),
		.load    (op_load_display_ctrl_1),
		.data    (accumulator),
		.value_q (display_ctrl_1)
	);

	// Display control 2
	atd_nibble_reg #(
		.WIDTH (4)
	) u_display_ctrl_2 (
		.mclk    (mclk),
		.reset   (reset),
		.load    (op_load_display_ctrl_2),
		.data    (accumulator),
		.value_q (display_ctrl_2)
	);

	// Display control 3
	atd_nibble_reg #(
		.WIDTH (4)
	) u_display_ctrl_3 (
		.mclk    (mclk),
		.reset   (reset),
		.load    (op_load_display_ctrl_3),
		.data    (accumulator),
		.value_q (display_ctrl_3)
	);

	// Reload value of the display clock timer
	atd_nibble_reg #(
		.WIDTH (4)
	) u_timer_reload (
		.mclk    (mclk),
		.reset   (reset),
		.load    (op_load_display_clock_timer),
		.data    (accumulator),
		.value_q (display_timer_reload)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Display clock timer

	logic [3:0] timer_count_q;
	logic [3:0] timer_count_d;
	logic       underflow_d;

	// Load beats a tick in the same cycle; underflow reloads from the reload register
	always_comb begin
		timer_count_d = timer_count_q;
		underflow_d   = 1'b0;
		if (op_load_display_clock_timer) begin
			timer_count_d = accumulator;
		end else if (timer_tick) begin
			if (timer_count_q == 4'h0) begin
				timer_count_d = display_timer_reload;
				underflow_d   = 1'b1;
			end else begin
				timer_count_d = timer_count_q - 4'h1;
			end
		end
	end

	// Running count and its underflow pulse
	always_ff @(posedge mclk) begin
		if (reset) begin
			timer_count_q     <= atd_pkg::NIBBLE_RESET;
			timer_underflow_q <= 1'b0;
		end else begin
			timer_count_q     <= timer_count_d;
			timer_underflow_q <= underflow_d;
		end
	end

	assign display_clock_timer = timer_count_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// RAM write port

	// One write strobe per store, address taken from the pointer of that cycle
	always_ff @(posedge mclk) begin
		if (reset) begin
			ram_wr_en_q   <= 1'b0;
			ram_wr_addr_q <= '0;
			ram_wr_data_q <= atd_pkg::NIBBLE_RESET;
			ram_imm_q     <= atd_pkg::NIBBLE_RESET;
		end else begin
			ram_wr_en_q <= op_store_to_ram;
			if (op_store_to_ram) begin
				ram_wr_addr_q <= ram_pointer;
				ram_wr_data_q <= accumulator;
				ram_imm_q     <= instr_word[atd_pkg::IMM_POS +: atd_pkg::IMM_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Completion and flag effects

	// Every word of the group finishes in its own cycle and leaves carry and skip alone
	always_ff @(posedge mclk) begin
		if (reset) begin
			op_group_q    <= 3'(atd_pkg::ATD_GRP_NONE);
			instr_done_q  <= 1'b0;
			carry_write_q <= 1'b0;
			skip_next_q   <= 1'b0;
		end else begin
			op_group_q    <= 3'(group_d);
			instr_done_q  <= any_op;
			carry_write_q <= 1'b0;
			skip_next_q   <= 1'b0;
		end
	end

endmodule // atd_decode

/* testbench/atd_decode_sva.sv */
// Purpose: Port assertions for atd_decode
// Assumes: Synchronous active-high reset on mclk
// Notes:   Bound to the design after the module
`timescale 1ns/1ps
module atd_decode_chk #(parameter int unsigned PTR_W = 6) (
	input logic				mclk,
	input logic				reset,
	input logic				instr_valid,
	input logic [9:0]		instr_word,
	input logic [3:0]		accumulator,
	input logic [PTR_W-1:0]	ram_pointer,
	input logic [3:0]		key_wakeup_ctrl_2,
	input logic [3:0]		display_ctrl_1,
	input logic [3:0]		display_ctrl_2,
	input logic [3:0]		display_ctrl_3,
	input logic [3:0]		display_clock_timer,
	input logic [3:0]		display_timer_reload,
	input logic				ram_wr_en_q,
	input logic [PTR_W-1:0]	ram_wr_addr_q,
	input logic [3:0]		ram_wr_data_q,
	input logic [2:0]		op_group_q,
	input logic				instr_done_q,
	input logic				carry_write_q,
	input logic				skip_next_q
);
	// Executed word, zero when nothing is presented or reset holds the core
	wire logic [9:0] op = (instr_valid && !reset) ? instr_word : 10'h000;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Each load copies the accumulator taken with its word
	AST_KEY_LOAD: assert property (op == 10'h215
		|=> key_wakeup_ctrl_2 == $past(accumulator)) else $error("key control load");
	AST_DISP1_LOAD: assert property (op == 10'h20A
		|=> display_ctrl_1 == $past(accumulator)) else $error("display 1 load");
	AST_DISP2_LOAD: assert property (op == 10'h20B
		|=> display_ctrl_2 == $past(accumulator)) else $error("display 2 load");
	AST_DISP3_LOAD: assert property (op == 10'h20C
		|=> display_ctrl_3 == $past(accumulator)) else $error("display 3 load");
	AST_TIMER_GROUP: assert property (op == 10'h20D
		|=> op_group_q == 3'h3 && instr_done_q) else $error("timer group");
	AST_TIMER_BOTH: assert property (op == 10'h20D
		|=> display_clock_timer == $past(accumulator) && display_timer_reload == $past(accumulator))
		else $error("timer load");
	AST_RAM_STORE: assert property (op[9:4] == 6'h2B
		|=> ram_wr_en_q && ram_wr_addr_q == $past(ram_pointer) && ram_wr_data_q == $past(accumulator))
		else $error("ram store");
	AST_NO_FLAGS: assert property (instr_done_q
		|-> !carry_write_q && !skip_next_q) else $error("carry or skip");
	// Main scenarios reached
	COV_STORE_PAIR: cover property (ram_wr_en_q ##1 ram_wr_en_q);
	COV_LOAD_RUN: cover property (instr_done_q [*3]);
	COV_TIMER: cover property (op_group_q == 3'h3);
endmodule // atd_decode_chk
bind atd_decode atd_decode_chk #(.PTR_W(PTR_W)) i_chk (.*);

/* testbench/tb_atd_decode.sv */
// Purpose: Self-checking bench for atd_decode
// Assumes: PTR_W left at 6
// Notes:   Directed cases, then a seeded xorshift stream
`timescale 1ns/1ps
module tb_atd_decode;
	logic		e_unf;
	logic [3:0]	e_imm;
	logic			mclk, reset, instr_valid, timer_tick, timer_underflow_q, ram_wr_en_q;
	logic			instr_done_q, carry_write_q, skip_next_q, e_wen;
	logic [9:0]		instr_word;
	logic [5:0]		ram_pointer, ram_wr_addr_q, e_adr;
	logic [3:0]		accumulator, key_wakeup_ctrl_2, display_ctrl_1, display_ctrl_2;
	logic [3:0]		display_ctrl_3, display_clock_timer, display_timer_reload;
	logic [3:0]		ram_wr_data_q, ram_imm_q, e_key, e_d1, e_d2, e_d3, e_tmr, e_rld, e_dat;
	logic [2:0]		op_group_q, e_grp;
	logic [31:0]	rng;
	logic [9:0]		ops [7] = '{10'h215, 10'h20A, 10'h20B, 10'h20C, 10'h20D, 10'h2B5, 10'h20E};
	int				n_fail, n_tests;

	atd_decode i_dut (.*);

	// 10 MHz clock
	always #50 mclk = ~mclk;

	// Xorshift step
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One edge: update reference from inputs just taken, drive new ones, compare
	task automatic step(input logic r, v, input logic [9:0] w, input logic t);
		@(posedge mclk);
		{e_grp, e_wen, e_unf} = '0;
		if (instr_valid) begin
			case (instr_word) inside
				10'h215: {e_grp, e_key} = {3'h1, accumulator};
				10'h20A: {e_grp, e_d1} = {3'h2, accumulator};
				10'h20B: {e_grp, e_d2} = {3'h2, accumulator};
				10'h20C: {e_grp, e_d3} = {3'h2, accumulator};
				10'h20D: {e_grp, e_tmr, e_rld} = {3'h3, accumulator, accumulator};
				[10'h2B0:10'h2BF]: {e_grp, e_wen, e_adr, e_dat, e_imm} =
					{3'h4, 1'b1, ram_pointer, accumulator, instr_word[3:0]};
				default: ;
			endcase
		end
		// A tick is lost while the timer loads
		if (timer_tick && e_grp != 3'h3) begin
			e_unf = (e_tmr == 4'h0);
			e_tmr = e_unf ? e_rld : e_tmr - 4'h1;
		end
		if (reset) begin
			{e_key, e_d1, e_d2, e_d3, e_tmr, e_rld, e_dat, e_adr} = '0;
			{e_grp, e_wen, e_imm, e_unf} = '0;
		end
		rng = xs(rng);
		reset <= r;
		instr_valid <= v;
		instr_word <= w;
		timer_tick <= t;
		{accumulator, ram_pointer} <= rng[9:0];
		#1;
		chk("key", key_wakeup_ctrl_2, e_key);
		chk("disp1", display_ctrl_1, e_d1);
		chk("disp2", display_ctrl_2, e_d2);
		chk("disp3", display_ctrl_3, e_d3);
		chk("group", {op_group_q, instr_done_q}, {e_grp, e_grp != 3'h0});
		chk("timer", {display_clock_timer, display_timer_reload}, {e_tmr, e_rld});
		chk("ram", {ram_wr_en_q, ram_wr_addr_q, ram_wr_data_q}, {e_wen, e_adr, e_dat});
		chk("ram_imm", ram_imm_q, e_imm);
		chk("underflow", timer_underflow_q, e_unf);
		chk("carry_skip", {carry_write_q, skip_next_q}, 2'h0);
	endtask

	// Reset, back-to-back ops, refused words with ticks, then random run
	initial begin
		logic [9:0] w;
		mclk = 1'b0;
		reset = 1'b1;
		{instr_valid, instr_word, accumulator, ram_pointer, timer_tick} = '0;
		rng = 32'hFEB75485;
		n_fail = 0;
		n_tests = 0;
		repeat (15) step(1'b1, 1'b0, 10'h000, 1'b0);
		foreach (ops[i]) step(1'b0, 1'b1, ops[i], 1'b1);
		repeat (20) step(1'b0, 1'b0, 10'h20D, 1'b1);
		for (int i = 0; i < 600; i++) begin
			w = rng[16] ? ops[rng[20:18] % 7] : rng[17] ? {6'h2B, rng[24:21]} : rng[30:21];
			step(rng[31:26] == 6'h00, rng[15:13] != 3'h0, w, rng[12]);
		end
		results();
	end
endmodule // tb_atd_decode
